// file: src/spd_decoder.sv
// Serial programming instruction decoder with its flash, EEPROM and fuse storage.
// Assumes the programmer clocks sck, pauses sck after byte 3 and after byte 4 (see hand-over).
// What this block does
// [R1] Each instruction is four bytes; the first three bytes select a read reply, the whole frame decides a write.
// [R2] While byte 3 shifts in, byte 2 of the enable instruction is echoed.
// [R3] AC 80 erases program memory and lock bits, and EEPROM only while high fuse bit 6 is one.
// [R4] F0 returns busy in bit 0 of byte 4.
// [R5] Programmer waits until busy reads zero before the next instruction; the bench sends one C0 during the C2 wait, and the decoder ignores it.
// [R6] 4D stores byte 3 as extended address.
// [R7] 48 writes byte 4 into high byte of the page buffer word.
// [R8] 40 writes byte 4 into low byte of the page buffer word.
// [R9] Programmer loads low byte before high byte of each word.
// [R10] C1 stores byte 4 into the EEPROM page buffer at address LSB.
// [R11] 28 and 20 return high and low program word bytes.
// [R12] 50 08 returns the extended fuse bits.
// [R13] 4C commits the flash page buffer and starts a timed operation.
// [R14] C2 commits the EEPROM page buffer to the addressed EEPROM page.
// [R15] AC A8 writes high fuses, AC A4 writes extended fuses.
// [R16] Fuse and lock bits: zero programmed, one unprogrammed.
// [R17] Program memory addresses are word addresses, any order in a page.
// [R18] Programmer toggles serial clock six times with reset low before entry.
// [R19] Data output is driven while the synchronised programming pin is low, from before the enable instruction.
// [R20] Programmer waits 50 us after entry before any instruction.
// [R21] Loaded command and address state are kept across operations.
// [R22] Address high byte is retained until the window changes.
// [R23] Remaining reads and writes: EEPROM, lock, signature, fuse, calibration.
// [R24] Programmer holds entry pins low while reset goes high.
`timescale 1ns/1ps
module spd_decoder #(
  parameter int unsigned FLASH_WAIT = spd_pkg::WD_FLASH_CYC,
  parameter int unsigned EE_WAIT = spd_pkg::WD_EEPROM_CYC,
  parameter int unsigned ERASE_WAIT = spd_pkg::WD_ERASE_CYC,
  parameter int unsigned FUSE_WAIT = spd_pkg::WD_FUSE_CYC
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic sck,
  input wire logic mosi,
  input wire logic prog_pin_n,
  output logic miso,
  output logic miso_oe_n,
  output logic prog_enabled,
  output logic busy
);
  // Word address from address MSB and LSB bytes
  function automatic logic [10:0] spd_waddr(input logic [7:0] msb, input logic [7:0] lsb);
    return {msb[2:0], lsb}; // R17
  endfunction

  logic rst_s1_q, rst_q;
  // Reset release through two flops
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_q <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_q <= rst_s1_q;
    end
  end

  // ---- Link side, rising edge: shift in and hand over header and frame
  logic [31:0] sh_q, sh_d;
  logic [4:0] cnt_q, cnt_d;
  spd_pkg::spd_hdr_t hdr_q, hdr_d;
  spd_pkg::spd_frame_t frm_q, frm_d;
  logic hdr_tgl_q, hdr_tgl_d, frm_tgl_q, frm_tgl_d;
  always_comb begin
    sh_d = {sh_q[30:0], mosi};
    cnt_d = cnt_q + 5'h01;
    hdr_d = hdr_q;
    frm_d = frm_q;
    hdr_tgl_d = hdr_tgl_q;
    frm_tgl_d = frm_tgl_q;
    if (cnt_q == spd_pkg::HDR_BIT) begin
      hdr_d = spd_pkg::spd_hdr_t'(sh_d[23:0]);
      hdr_tgl_d = ~hdr_tgl_q;
    end
    if (cnt_q == spd_pkg::FRAME_BIT) begin
      frm_d = spd_pkg::spd_frame_t'(sh_d); // R1
      frm_tgl_d = ~frm_tgl_q;
    end
  end
  always_ff @(posedge sck or negedge rst_q) begin
    if (!rst_q) begin
      sh_q <= 32'h0;
      cnt_q <= 5'h0;
      hdr_q <= '0;
      frm_q <= '0;
      hdr_tgl_q <= 1'b0;
      frm_tgl_q <= 1'b0;
    end else begin
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      hdr_q <= hdr_d;
      frm_q <= frm_d;
      hdr_tgl_q <= hdr_tgl_d;
      frm_tgl_q <= frm_tgl_d;
    end
  end

  // ---- Link side, falling edge: output shifter; reply taken after the idle gap
  logic [7:0] out_q, out_d, reply_q;
  logic miso_q, miso_d, rep_tgl_q;
  always_comb begin
    out_d = {out_q[6:0], 1'b0};
    if (cnt_q == spd_pkg::ECHO_BIT) begin
      out_d = (sh_q[15:8] == spd_pkg::OP_WRITE_GRP) ? sh_q[7:0] : 8'h00; // R2
    end else if (cnt_q == spd_pkg::REPLY_BIT) begin
      // sck stands still after byte 3, so a synchroniser on it would never advance;
      // the mandatory idle gap leaves reply and toggle settled for this one edge
      out_d = (rep_tgl_q == hdr_tgl_q) ? reply_q : 8'h00; // R4 R11
    end
    miso_d = out_d[7];
  end
  always_ff @(negedge sck or negedge rst_q) begin
    if (!rst_q) begin
      out_q <= 8'h00;
      miso_q <= 1'b0;
    end else begin
      out_q <= out_d;
      miso_q <= miso_d;
    end
  end
  assign miso = miso_q;

  // ---- System side: synchronisers for toggles and the programming pin
  logic hs1_q, hs2_q, hs3_q, fs1_q, fs2_q, fs3_q, ps1_q, ps2_q;
  always_ff @(posedge sys_clk or negedge rst_q) begin
    if (!rst_q) begin
      {hs1_q, hs2_q, hs3_q} <= 3'h0;
      {fs1_q, fs2_q, fs3_q} <= 3'h0;
      {ps1_q, ps2_q} <= 2'h3;
    end else begin
      {hs1_q, hs2_q, hs3_q} <= {hdr_tgl_q, hs1_q, hs2_q};
      {fs1_q, fs2_q, fs3_q} <= {frm_tgl_q, fs1_q, fs2_q};
      {ps1_q, ps2_q} <= {prog_pin_n, ps1_q};
    end
  end
  wire logic hdr_ev = hs2_q ^ hs3_q;
  wire logic frm_ev = fs2_q ^ fs3_q;
  wire logic session = ~ps2_q;

  // ---- System side: storage and control state
  logic [15:0] flash_q [spd_pkg::FLASH_WORDS], flash_d [spd_pkg::FLASH_WORDS];
  logic [15:0] pbuf_q [spd_pkg::PAGE_WORDS], pbuf_d [spd_pkg::PAGE_WORDS];
  logic [7:0] ee_q [spd_pkg::EE_BYTES], ee_d [spd_pkg::EE_BYTES];
  logic [7:0] epbuf_q [spd_pkg::EE_PAGE], epbuf_d [spd_pkg::EE_PAGE];
  logic [3:0] epmask_q, epmask_d;
  logic [7:0] lock_q, lock_d, fuse_lo_q, fuse_lo_d, fuse_hi_q, fuse_hi_d, fuse_ext_q, fuse_ext_d;
  logic [7:0] ext_q, ext_d, reply_d;
  logic [16:0] bcnt_q, bcnt_d;
  logic en_q, en_d, busy_q, rep_tgl_d, oe_n_q;
  wire logic busy_now = bcnt_q != 17'h0;
  wire logic [10:0] fa = spd_waddr(frm_q.b2, frm_q.b3);
  wire logic [10:0] ha = spd_waddr(hdr_q.b2, hdr_q.b3);
  wire logic [4:0] pidx = fa[4:0];
  wire logic x_exec = frm_ev && session && en_q && !busy_now; // R5

  // Next state: reply preparation and frame execution
  always_comb begin
    flash_d = flash_q;
    pbuf_d = pbuf_q;
    ee_d = ee_q;
    epbuf_d = epbuf_q;
    epmask_d = epmask_q;
    lock_d = lock_q;
    fuse_lo_d = fuse_lo_q;
    fuse_hi_d = fuse_hi_q;
    fuse_ext_d = fuse_ext_q;
    ext_d = ext_q; // R21 R22
    en_d = en_q && session;
    bcnt_d = busy_now ? bcnt_q - 17'h1 : bcnt_q;
    reply_d = reply_q;
    rep_tgl_d = rep_tgl_q;
    if (hdr_ev) begin
      rep_tgl_d = hs2_q;
      reply_d = 8'h00;
      if (en_q) begin
        case (hdr_q.op)
          spd_pkg::OP_POLL: reply_d = {7'h00, busy_now}; // R4
          spd_pkg::OP_RD_HI: reply_d = flash_q[ha][15:8]; // R11
          spd_pkg::OP_RD_LO: reply_d = flash_q[ha][7:0]; // R11
          spd_pkg::OP_RD_EE: reply_d = ee_q[hdr_q.b3]; // R23
          spd_pkg::OP_RD_CAL: reply_d = spd_pkg::CAL_RST; // R23
          spd_pkg::OP_RD_SIG: begin
            reply_d = (hdr_q.b3[1:0] == 2'h0) ? spd_pkg::SIG0 : (hdr_q.b3[1:0] == 2'h1) ? spd_pkg::SIG1 :
                      (hdr_q.b3[1:0] == 2'h2) ? spd_pkg::SIG2 : 8'h00; // R23
          end
          spd_pkg::OP_RD_FUSE: reply_d = (hdr_q.b2 == spd_pkg::B2_HI_SEL) ? fuse_ext_q : fuse_lo_q; // R12
          spd_pkg::OP_RD_LOCK_HI: reply_d = (hdr_q.b2 == spd_pkg::B2_HI_SEL) ? fuse_hi_q : lock_q; // R23
          default: reply_d = 8'h00;
        endcase
      end
    end
    if (frm_ev && session && frm_q.op == spd_pkg::OP_WRITE_GRP && frm_q.b2 == spd_pkg::B2_PROG_EN) begin
      en_d = 1'b1;
    end else if (x_exec) begin
      case (frm_q.op)
        spd_pkg::OP_WRITE_GRP: begin
          case (frm_q.b2)
            spd_pkg::B2_ERASE: begin
              for (int i = 0; i < spd_pkg::FLASH_WORDS; i++) flash_d[i] = spd_pkg::ERASED_WORD; // R3
              if (fuse_hi_q[spd_pkg::EEPROM_PRESERVE_FUSE_POS]) begin
                for (int i = 0; i < spd_pkg::EE_BYTES; i++) ee_d[i] = spd_pkg::ERASED_BYTE; // R16
              end
              lock_d = spd_pkg::ERASED_BYTE;
              bcnt_d = 17'(ERASE_WAIT);
            end
            spd_pkg::B2_LOCK: begin
              lock_d = frm_q.b4; // R23
              bcnt_d = 17'(FUSE_WAIT);
            end
            spd_pkg::B2_FUSE_LO: begin
              fuse_lo_d = frm_q.b4; // R23
              bcnt_d = 17'(FUSE_WAIT);
            end
            spd_pkg::B2_FUSE_HI: begin
              fuse_hi_d = frm_q.b4; // R15
              bcnt_d = 17'(FUSE_WAIT);
            end
            spd_pkg::B2_FUSE_EXT: begin
              fuse_ext_d = frm_q.b4; // R15
              bcnt_d = 17'(FUSE_WAIT);
            end
            default: ;
          endcase
        end
        spd_pkg::OP_EXT_ADR: ext_d = frm_q.b3; // R6
        spd_pkg::OP_LD_HI: pbuf_d[pidx][15:8] = frm_q.b4; // R7
        spd_pkg::OP_LD_LO: pbuf_d[pidx][7:0] = frm_q.b4; // R8
        spd_pkg::OP_LD_EE: begin
          epbuf_d[frm_q.b3[1:0]] = frm_q.b4; // R10
          epmask_d[frm_q.b3[1:0]] = 1'b1;
        end
        spd_pkg::OP_WR_PAGE: begin
          for (int i = 0; i < spd_pkg::PAGE_WORDS; i++) flash_d[{fa[10:5], i[4:0]}] = pbuf_q[i]; // R13
          bcnt_d = 17'(FLASH_WAIT);
        end
        spd_pkg::OP_WR_EE_PAGE: begin
          for (int i = 0; i < spd_pkg::EE_PAGE; i++) begin
            if (epmask_q[i]) ee_d[{frm_q.b3[7:2], i[1:0]}] = epbuf_q[i]; // R14
          end
          epmask_d = 4'h0;
          bcnt_d = 17'(EE_WAIT);
        end
        spd_pkg::OP_WR_EE: begin
          ee_d[frm_q.b3] = frm_q.b4; // R23
          bcnt_d = 17'(EE_WAIT);
        end
        default: ;
      endcase
    end
  end

  // Control registers
  always_ff @(posedge sys_clk or negedge rst_q) begin
    if (!rst_q) begin
      en_q <= 1'b0;
      bcnt_q <= 17'h0;
      busy_q <= 1'b0;
      oe_n_q <= 1'b1;
      reply_q <= 8'h00;
      rep_tgl_q <= 1'b0;
      ext_q <= 8'h00;
      epmask_q <= 4'h0;
      lock_q <= spd_pkg::LOCK_RST;
      fuse_lo_q <= spd_pkg::FUSE_LO_RST;
      fuse_hi_q <= spd_pkg::FUSE_HI_RST;
      fuse_ext_q <= spd_pkg::FUSE_EXT_RST;
    end else begin
      en_q <= en_d;
      bcnt_q <= bcnt_d;
      busy_q <= bcnt_d != 17'h0;
      oe_n_q <= ~session; // R19
      reply_q <= reply_d;
      rep_tgl_q <= rep_tgl_d;
      ext_q <= ext_d;
      epmask_q <= epmask_d;
      lock_q <= lock_d;
      fuse_lo_q <= fuse_lo_d;
      fuse_hi_q <= fuse_hi_d;
      fuse_ext_q <= fuse_ext_d;
    end
  end

  // Memory arrays, no reset
  always_ff @(posedge sys_clk) begin
    flash_q <= flash_d;
    pbuf_q <= pbuf_d;
    ee_q <= ee_d;
    epbuf_q <= epbuf_d;
  end

  assign miso_oe_n = oe_n_q;
  assign prog_enabled = en_q;
  assign busy = busy_q;

  // Checks on the system side
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_q);
  sequence s_cmd(logic [7:0] o);
    x_exec && frm_q.op == o;
  endsequence
  sequence s_held_busy;
    busy ##1 busy;
  endsequence
  enable_set_a: assert property (frm_ev && session && frm_q.op == spd_pkg::OP_WRITE_GRP && // R1
    frm_q.b2 == spd_pkg::B2_PROG_EN |=> prog_enabled) else $error("enable not set");
  erase_all_a: assert property (s_cmd(spd_pkg::OP_WRITE_GRP) and (frm_q.b2 == spd_pkg::B2_ERASE) |=> // R3
    flash_q[0] == spd_pkg::ERASED_WORD && lock_q == spd_pkg::ERASED_BYTE && busy) else $error("erase wrong");
  poll_reply_a: assert property (hdr_ev && en_q && hdr_q.op == spd_pkg::OP_POLL |=> // R4
    reply_q[0] == $past(busy_now) && reply_q[7:1] == 7'h00) else $error("poll reply wrong");
  ext_addr_a: assert property (s_cmd(spd_pkg::OP_EXT_ADR) |=> ext_q == $past(frm_q.b3)) else // R6
    $error("extended address not stored");
  load_high_a: assert property (s_cmd(spd_pkg::OP_LD_HI) |=> // R7
    pbuf_q[$past(pidx)][15:8] == $past(frm_q.b4)) else $error("high byte not loaded");
  load_low_a: assert property (s_cmd(spd_pkg::OP_LD_LO) |=> // R8
    pbuf_q[$past(pidx)][7:0] == $past(frm_q.b4)) else $error("low byte not loaded");
  commit_busy_a: assert property (s_cmd(spd_pkg::OP_WR_PAGE) |=> s_held_busy) else $error("no busy after commit"); // R13
  fuse_high_a: assert property (s_cmd(spd_pkg::OP_WRITE_GRP) and (frm_q.b2 == spd_pkg::B2_FUSE_HI) |=> // R15
    fuse_hi_q == $past(frm_q.b4)) else $error("high fuse not written");
  out_enable_a: assert property (!session |=> miso_oe_n) else $error("output driven off"); // R19
  out_drive_a: assert property (session |=> !miso_oe_n) else $error("output not driven in session"); // R19
  // Check on the link side
  echo_byte_a: assert property (@(negedge sck) disable iff (!rst_q) // R2
    cnt_q == spd_pkg::ECHO_BIT && sh_q[15:0] == {spd_pkg::OP_WRITE_GRP, spd_pkg::B2_PROG_EN} |=>
    out_q == spd_pkg::B2_PROG_EN) else $error("echo missing");
endmodule

// file: src/spd_pkg.sv
// Constants and carriers for the serial programming instruction decoder.
// Assumes a 20 MHz system clock; the link side runs on the programmer's serial clock.
package spd_pkg;
  // Opcodes and second-byte selectors
  localparam logic [7:0] OP_WRITE_GRP = 8'hAC;
  localparam logic [7:0] B2_PROG_EN = 8'h53;
  localparam logic [7:0] B2_ERASE = 8'h80;
  localparam logic [7:0] B2_LOCK = 8'hE0;
  localparam logic [7:0] B2_FUSE_LO = 8'hA0;
  localparam logic [7:0] B2_FUSE_HI = 8'hA8;
  localparam logic [7:0] B2_FUSE_EXT = 8'hA4;
  localparam logic [7:0] B2_HI_SEL = 8'h08;
  localparam logic [7:0] OP_POLL = 8'hF0;
  localparam logic [7:0] OP_EXT_ADR = 8'h4D;
  localparam logic [7:0] OP_LD_HI = 8'h48;
  localparam logic [7:0] OP_LD_LO = 8'h40;
  localparam logic [7:0] OP_LD_EE = 8'hC1;
  localparam logic [7:0] OP_RD_HI = 8'h28;
  localparam logic [7:0] OP_RD_LO = 8'h20;
  localparam logic [7:0] OP_RD_EE = 8'hA0;
  localparam logic [7:0] OP_RD_LOCK_HI = 8'h58;
  localparam logic [7:0] OP_RD_SIG = 8'h30;
  localparam logic [7:0] OP_RD_FUSE = 8'h50;
  localparam logic [7:0] OP_RD_CAL = 8'h38;
  localparam logic [7:0] OP_WR_PAGE = 8'h4C;
  localparam logic [7:0] OP_WR_EE = 8'hC0;
  localparam logic [7:0] OP_WR_EE_PAGE = 8'hC2;
  // Bit positions within a frame, counted from zero
  localparam logic [4:0] ECHO_BIT = 5'h10;
  localparam logic [4:0] HDR_BIT = 5'h17;
  localparam logic [4:0] REPLY_BIT = 5'h18;
  localparam logic [4:0] FRAME_BIT = 5'h1F;
  // Memory geometry
  localparam int FLASH_WORDS = 2048;
  localparam int PAGE_WORDS = 32;
  localparam int EE_BYTES = 256;
  localparam int EE_PAGE = 4;
  localparam int EEPROM_PRESERVE_FUSE_POS = 6;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  // Values after reset; signature and calibration values are arbitrary
  localparam logic [7:0] FUSE_LO_RST = 8'hFF;
  localparam logic [7:0] FUSE_HI_RST = 8'hFF;
  localparam logic [7:0] FUSE_EXT_RST = 8'hFF;
  localparam logic [7:0] LOCK_RST = 8'hFF;
  localparam logic [7:0] SIG0 = 8'h01;
  localparam logic [7:0] SIG1 = 8'h02;
  localparam logic [7:0] SIG2 = 8'h03;
  localparam logic [7:0] CAL_RST = 8'h80;
  // Self-timed operation lengths
  localparam int CLK_PERIOD_NS = 50;
  localparam int T_WD_FLASH_US = 4500;
  localparam int T_WD_EEPROM_US = 4000;
  localparam int T_WD_ERASE_US = 4000;
  localparam int T_WD_FUSE_US = 4500;
  localparam int WD_FLASH_CYC = T_WD_FLASH_US * 1000 / CLK_PERIOD_NS;
  localparam int WD_EEPROM_CYC = T_WD_EEPROM_US * 1000 / CLK_PERIOD_NS;
  localparam int WD_ERASE_CYC = T_WD_ERASE_US * 1000 / CLK_PERIOD_NS;
  localparam int WD_FUSE_CYC = T_WD_FUSE_US * 1000 / CLK_PERIOD_NS;
  // Header (first three bytes) and whole four-byte frame
  typedef struct packed {
    logic [7:0] op;
    logic [7:0] b2;
    logic [7:0] b3;
  } spd_hdr_t;
  typedef struct packed {
    logic [7:0] op;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [7:0] b4;
  } spd_frame_t;
endpackage

// file: verif/spd_prog_model.sv
// Programmer model: shifts four-byte instructions onto the link and gathers the reply.
// Assumes the decoder samples on rising sck and shifts its answer out on falling sck.
`timescale 1ns/1ps
module spd_prog_model #(
  parameter int HALF_NS = 3,
  parameter int PAUSE_NS = 500
) (
  output logic sck,
  output logic mosi,
  input wire logic miso
);
  // Link clock stands low outside frames
  initial begin
    sck = 1'b0;
    mosi = 1'b0;
  end

  // Entry clock pulses with data low; only used while the device is held in reset
  task automatic idle_clocks(input int n);
    for (int k = 0; k < n; k++) begin
      #(HALF_NS) sck = 1'b1;
      #(HALF_NS) sck = 1'b0;
    end
  endtask

  // One whole frame, MSB first; echo and reply are taken on rising edges
  task automatic xfer(input logic [31:0] tx, output spd_pkg::spd_frame_t rx);
    logic [31:0] got;
    got = '0;
    for (int i = 31; i >= 0; i--) begin
      mosi = tx[i];
      #(HALF_NS);
      sck = 1'b1;
      got = {got[30:0], miso};
      // Idle after the header so the system side can prepare the reply
      if (i == 8) #(PAUSE_NS);
      #(HALF_NS);
      sck = 1'b0;
    end
    rx = got;
    mosi = ~mosi; // Released line no longer shows the last bit
    #(PAUSE_NS);
  endtask
endmodule

// file: verif/testbench.sv
// Self-checking bench for the serial programming instruction decoder.
// Assumes the programmer model in its own file and short self-timed waits.
`timescale 1ns/1ps
module testbench;
  localparam int WAIT_CYC = 60;
  localparam int ENTRY_WAIT_CYC = 1000;
  logic sys_clk, nrst, prog_pin_n, sck, mosi, miso, miso_oe_n, prog_enabled, busy;
  // Released pin is seen as the inverse of the last driven level
  wire logic miso_line = miso_oe_n ? ~miso : miso;
  int fail_count, comparisons;
  spd_pkg::spd_frame_t rx;

  // System clock, 50 ns period
  initial sys_clk = 1'b0;
  always #25 sys_clk = ~sys_clk;

  spd_decoder #(.FLASH_WAIT(WAIT_CYC), .EE_WAIT(WAIT_CYC), .ERASE_WAIT(WAIT_CYC), .FUSE_WAIT(WAIT_CYC)) u_dut (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .sck(sck),
    .mosi(mosi),
    .prog_pin_n(prog_pin_n),
    .miso(miso),
    .miso_oe_n(miso_oe_n),
    .prog_enabled(prog_enabled),
    .busy(busy)
  );

  spd_prog_model u_prog (.sck(sck), .mosi(mosi), .miso(miso_line));

  // Compares one value and counts it
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic run(input logic [31:0] f);
    u_prog.xfer(f, rx);
  endtask

  // Polls until the pending operation has finished
  task automatic wait_idle();
    for (int n = 0; n < 20; n++) begin
      run(32'hF000_0000);
      if (rx.b4[0] === 1'b0) break;
    end
    check("poll idle", {7'h00, rx.b4[0]}, 8'h00);
    check("busy cleared", {7'h00, busy}, 8'h00);
  endtask

  task automatic test_refused();
    check("pin driven", {7'h00, miso_oe_n}, 8'h00);
    run(32'h5800_0000);
    check("read before enable", rx.b4, 8'h00);
    check("enable idle", {7'h00, prog_enabled}, 8'h00);
    $display("Test refused finished");
  endtask

  task automatic test_enable();
    run(32'hAC53_0000);
    check("enable echo", rx.b3, 8'h53);
    check("enable flag", {7'h00, prog_enabled}, 8'h01);
    $display("Test enable finished");
  endtask

  task automatic test_reads();
    logic [31:0] f [7] = '{32'h3000_0000, 32'h3000_0100, 32'h3000_0200, 32'h3800_0000,
                           32'h5000_0000, 32'h5808_0000, 32'h5800_0000};
    logic [7:0] e [7] = '{spd_pkg::SIG0, spd_pkg::SIG1, spd_pkg::SIG2, spd_pkg::CAL_RST,
                          spd_pkg::FUSE_LO_RST, spd_pkg::FUSE_HI_RST, spd_pkg::LOCK_RST};
    for (int i = 0; i < 7; i++) begin
      run(f[i]);
      check("reset value read", rx.b4, e[i]);
    end
    run(32'h5008_0000);
    check("ext fuse read", rx.b4, spd_pkg::FUSE_EXT_RST);
    $display("Test reads finished");
  endtask

  task automatic test_flash();
    logic [31:0] f [4] = '{32'h2000_0500, 32'h2800_0500, 32'h2000_0200, 32'h2800_0200};
    logic [7:0] e [4] = '{8'hAA, 8'hBB, 8'h11, 8'h22};
    run(32'h4000_05AA);
    run(32'h4800_05BB);
    run(32'h4000_0211);
    run(32'h4800_0222);
    run(32'h4D00_0000);
    run(32'h4C00_0000);
    check("flash commit busy", {7'h00, busy}, 8'h01);
    run(32'hF000_0000);
    check("poll while busy", {7'h00, rx.b4[0]}, 8'h01);
    wait_idle();
    for (int i = 0; i < 4; i++) begin
      run(f[i]);
      check("flash word byte", rx.b4, e[i]);
    end
    $display("Test flash finished");
  endtask

  task automatic test_eeprom();
    run(32'hC100_015A);
    run(32'hC100_02A5);
    run(32'hC200_0000);
    check("eeprom commit busy", {7'h00, busy}, 8'h01);
    run(32'hC000_0100);
    wait_idle();
    run(32'hA000_0100);
    check("eeprom page byte 1", rx.b4, 8'h5A);
    run(32'hA000_0200);
    check("eeprom page byte 2", rx.b4, 8'hA5);
    run(32'hC000_103C);
    wait_idle();
    run(32'hA000_1000);
    check("eeprom byte write", rx.b4, 8'h3C);
    $display("Test eeprom finished");
  endtask

  task automatic test_fuses();
    logic [31:0] w [4] = '{32'hACA8_00F7, 32'hACA4_00FE, 32'hACA0_00E2, 32'hACE0_00FC};
    logic [31:0] r [4] = '{32'h5808_0000, 32'h5008_0000, 32'h5000_0000, 32'h5800_0000};
    for (int i = 0; i < 4; i++) begin
      run(w[i]);
      check("write echo", rx.b3, w[i][23:16]);
      wait_idle();
      run(r[i]);
      check("fuse or lock readback", rx.b4, w[i][7:0]);
    end
    $display("Test fuses finished");
  endtask

  task automatic test_erase();
    run(32'hAC80_0000);
    check("erase echo", rx.b3, 8'h80);
    check("erase busy", {7'h00, busy}, 8'h01);
    wait_idle();
    run(32'h2000_0500);
    check("flash erased", rx.b4, 8'hFF);
    run(32'hA000_0100);
    check("eeprom erased", rx.b4, 8'hFF);
    run(32'h5800_0000);
    check("lock erased", rx.b4, 8'hFF);
    run(32'h5808_0000);
    check("fuse kept", rx.b4, 8'hF7);
    $display("Test erase finished");
  endtask

  task automatic test_session_end();
    @(posedge sys_clk);
    #1 prog_pin_n = 1'b1;
    repeat (5) @(posedge sys_clk);
    #1;
    check("enable dropped", {7'h00, prog_enabled}, 8'h00);
    check("pin released", {7'h00, miso_oe_n}, 8'h01);
    run(32'h5800_0000);
    check("read outside session", rx.b4, 8'hFF);
    $display("Test session_end finished");
  endtask

  // Prints the counts and the verdict, then stops
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Main sequence
  initial begin
    nrst = 1'b0;
    prog_pin_n = 1'b0;
    fail_count = 0;
    comparisons = 0;
    repeat (5) @(posedge sys_clk);
    u_prog.idle_clocks(6);
    repeat (5) @(posedge sys_clk);
    #1 nrst = 1'b1;
    repeat (ENTRY_WAIT_CYC) @(posedge sys_clk);
    #1;
    test_refused();
    test_enable();
    test_reads();
    test_flash();
    test_eeprom();
    test_fuses();
    test_erase();
    test_session_end();
    complete_run();
  end

  // Watchdog, well beyond the expected run time
  initial begin
    #2000000;
    fail_count++;
    $display("Watchdog expired");
    complete_run();
  end
endmodule
